//--- core/guard_pkg.sv
// constants and carrier types for the guard timer and reset-cause unit
package guard_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_RESET_CAUSE   = 8'hEF;
    localparam logic [7:0] REG_GUARD_CONTROL = 8'hFF;

    // ---------------------------------------------------------------
    // guard control keys and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] KEY_RESTART    = 8'hA5;
    localparam logic [7:0] KEY_DISABLE_1  = 8'hDE;
    localparam logic [7:0] KEY_DISABLE_2  = 8'hAD;
    localparam logic [7:0] KEY_LOCK       = 8'hFF;
    localparam int         GC_KEY_BIT     = 7;
    localparam int         GC_ACTIVE_BIT  = 4;
    localparam logic [2:0] INTERVAL_RESET = 3'h7;
    localparam logic [4:0] INTERVAL_BASE  = 5'h3;

    // ---------------------------------------------------------------
    // reset cause bit positions
    // ---------------------------------------------------------------
    localparam int RC_CONVERT  = 6;
    localparam int RC_COMPARE  = 5;
    localparam int RC_SOFTWARE = 4;
    localparam int RC_GUARD    = 3;
    localparam int RC_MISSING  = 2;
    localparam int RC_POWER_ON = 1;
    localparam int RC_PIN      = 0;
    localparam logic [6:0] CAUSE_POWER_ON_VALUE = 7'h02;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int         CLK_PERIOD_NS      = 40;
    localparam int         HOLD_TIME_NS       = 480;
    localparam int         HOLD_CYCLES        = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] DISABLE_WINDOW     = 3'h4;
    localparam int         PIN_MASK_CYCLES    = 3;

    // ---------------------------------------------------------------
    // carrier for the register port
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

endpackage

//--- core/guard_reset_unit.sv
// guard timer with keyed control and reset-cause recording
//
// Function
// - guard timer is a 21-bit counter on the system clock between restarts
// - overflow while enabled puts the whole chip into reset
// - after any system reset timer enabled, running, interval 111b
// - writing 0xA5 enables the timer and restarts the count
// - 0xDE then 0xAD within 4 cycles disables; otherwise ignored
// - writing 0xFF locks out disabling until next system reset
// - the 0xFF write neither enables nor restarts the timer
// - timeout is four to the power (3 + interval) clock periods
// - interval updates only on writes with bit 7 clear
// - control read gives interval in [2:0] and active state in bit 4
// - guard overflow reset leaves the external reset pin alone
// - cause bit 3 set when last reset was guard overflow
// - cause bit 6 enables convert-start input as active-low reset; reads cause
// - cause bit 5 enables comparator as active-low reset; reads cause
// - writing 1 to cause bit 4 forces internal reset, pin untouched
// - cause bit 2 enables missing-clock reset; reads cause
// - cause bit 1 selects supply monitor when its pin enables it
// - other flags may be anything while power-on flag reads one
// - writing 1 to cause bit 0 forces power-on reset, drives pin low
// - power-on flag cleared by every non power-on reset
`timescale 1ns/10ps
`default_nettype none

module guard_reset_unit
#(
    parameter int CNT_W = 21
)
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire guard_pkg::bus_req_t i_bus,
    output var  logic [7:0]        o_rd_data,
    input  wire logic              i_rst_pin_in,
    output var  logic              o_rst_pin_out,
    output var  logic              o_rst_pin_oe,
    input  wire logic              i_convert_start_input,
    input  wire logic              i_comparator_out,
    input  wire logic              i_missing_clock,
    input  wire logic              i_supply_low,
    input  wire logic              i_supply_monitor_enable_pin,
    output var  logic              o_sys_reset,
    output var  logic              o_guard_active
);
    import guard_pkg::*;

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [5:0] async_raw;
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;

    assign async_raw = {i_supply_monitor_enable_pin, i_supply_low, i_missing_clock,
                        i_comparator_out, i_convert_start_input, i_rst_pin_in};

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= 6'h3F;
            sync2_q <= 6'h3F;
        end else begin
            sync1_q <= async_raw;
            sync2_q <= sync1_q;
        end
    end

    logic pin_s;
    logic convert_s;
    logic compare_s;
    logic missing_s;
    logic supply_low_s;
    logic monitor_pin_s;

    assign pin_s         = sync2_q[0];
    assign convert_s     = sync2_q[1];
    assign compare_s     = sync2_q[2];
    assign missing_s     = sync2_q[3];
    assign supply_low_s  = sync2_q[4];
    assign monitor_pin_s = sync2_q[5];

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    logic       sys_reset_q;
    logic       wr_gc;
    logic       wr_rc;
    logic [7:0] wd;

    // writes are ignored while the chip is held in reset
    assign wd    = i_bus.wdata;
    assign wr_gc = i_bus.wr && !sys_reset_q && (i_bus.addr == REG_GUARD_CONTROL);
    assign wr_rc = i_bus.wr && !sys_reset_q && (i_bus.addr == REG_RESET_CAUSE);

    // ---------------------------------------------------------------
    // guard timer
    // ---------------------------------------------------------------
    logic             guard_en_q;
    logic             lock_q;
    logic [2:0]       interval_q;
    logic [2:0]       window_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] limit;
    logic [4:0]       shift_amt;
    logic             overflow;

    assign shift_amt = 5'((INTERVAL_BASE + {2'h0, interval_q}) << 1);
    assign limit     = CNT_W'(CNT_W'(1) << shift_amt) - CNT_W'(1);
    assign overflow  = guard_en_q && (count_q == limit);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            guard_en_q <= 1'b1;
            lock_q     <= 1'b0;
            interval_q <= INTERVAL_RESET;
            window_q   <= 3'h0;
            count_q    <= '0;
        end else if (sys_reset_q) begin
            guard_en_q <= 1'b1;
            lock_q     <= 1'b0;
            interval_q <= INTERVAL_RESET;
            window_q   <= 3'h0;
            count_q    <= '0;
        end else begin
            if (guard_en_q) begin
                count_q <= count_q + CNT_W'(1);
            end
            if (window_q != 3'h0) begin
                window_q <= window_q - 3'h1;
            end
            if (wr_gc) begin
                // any other write closes the window
                window_q <= 3'h0;
                if (wd == KEY_RESTART) begin
                    guard_en_q <= 1'b1;
                    count_q    <= '0;
                end else if (wd == KEY_DISABLE_1) begin
                    window_q <= DISABLE_WINDOW;
                end else if (wd == KEY_DISABLE_2) begin
                    if (window_q != 3'h0 && !lock_q) begin
                        guard_en_q <= 1'b0;
                    end
                end else if (wd == KEY_LOCK) begin
                    lock_q <= 1'b1;
                end
                // interval written only with key bit clear
                if (!wd[GC_KEY_BIT]) begin
                    interval_q <= wd[2:0];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // reset source enables
    // ---------------------------------------------------------------
    logic convert_en_q;
    logic compare_en_q;
    logic missing_en_q;
    logic monitor_sel_q;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            convert_en_q  <= 1'b0;
            compare_en_q  <= 1'b0;
            missing_en_q  <= 1'b0;
            monitor_sel_q <= 1'b1;
        end else if (sys_reset_q) begin
            convert_en_q  <= 1'b0;
            compare_en_q  <= 1'b0;
            missing_en_q  <= 1'b0;
            monitor_sel_q <= 1'b1;
        end else if (wr_rc) begin
            convert_en_q <= wd[RC_CONVERT];
            compare_en_q <= wd[RC_COMPARE];
            missing_en_q <= wd[RC_MISSING];
            if (monitor_pin_s) begin
                monitor_sel_q <= wd[RC_POWER_ON];
            end
        end
    end

    // ---------------------------------------------------------------
    // reset triggers
    // ---------------------------------------------------------------
    logic [PIN_MASK_CYCLES-1:0] pin_drive_hist_q;
    logic                       pin_masked;
    logic                       trig_supply;
    logic                       trig_por_sw;
    logic                       trig_pin;
    logic                       trig_convert;
    logic                       trig_compare;
    logic                       trig_missing;
    logic                       trig_soft;
    logic                       trig_any;
    logic                       hold_level;
    logic [6:0]                 cause_d;

    // own drive must not read back as a pin reset through the synchroniser
    assign pin_masked   = o_rst_pin_oe || (pin_drive_hist_q != '0);
    assign trig_supply  = supply_low_s && monitor_pin_s && monitor_sel_q;
    assign trig_por_sw  = wr_rc && wd[RC_PIN];
    assign trig_pin     = !pin_s && !pin_masked;
    assign trig_convert = convert_en_q && !convert_s;
    assign trig_compare = compare_en_q && !compare_s;
    assign trig_missing = missing_en_q && missing_s;
    assign trig_soft    = wr_rc && wd[RC_SOFTWARE];
    assign trig_any     = trig_supply || trig_por_sw || trig_pin || trig_convert ||
                          trig_compare || trig_missing || trig_soft || overflow;
    assign hold_level   = trig_supply || trig_pin;

    always_comb begin
        cause_d = 7'h00;
        if (trig_supply || trig_por_sw) begin
            // monitor and power-on share the flag
            cause_d[RC_POWER_ON] = 1'b1;
        end else if (trig_pin) begin
            cause_d[RC_PIN] = 1'b1;
        end else if (trig_convert) begin
            cause_d[RC_CONVERT] = 1'b1;
        end else if (trig_compare) begin
            cause_d[RC_COMPARE] = 1'b1;
        end else if (trig_missing) begin
            cause_d[RC_MISSING] = 1'b1;
        end else if (trig_soft) begin
            cause_d[RC_SOFTWARE] = 1'b1;
        end else begin
            cause_d[RC_GUARD] = overflow;
        end
    end

    // ---------------------------------------------------------------
    // reset sequencer
    // ---------------------------------------------------------------
    logic [7:0] hold_q;
    logic [6:0] cause_q;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sys_reset_q <= 1'b1;
            hold_q      <= 8'(HOLD_CYCLES);
        end else if (!sys_reset_q) begin
            if (trig_any) begin
                sys_reset_q <= 1'b1;
                hold_q      <= 8'(HOLD_CYCLES);
            end
        end else if (hold_level) begin
            hold_q <= 8'(HOLD_CYCLES);
        end else if (hold_q != 8'h00) begin
            hold_q <= hold_q - 8'h01;
        end else begin
            sys_reset_q <= 1'b0;
        end
    end

    // every non power-on reset rewrites the whole flag set
    // other flags cleared on power-on, a legal choice
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cause_q <= CAUSE_POWER_ON_VALUE;
        end else if (!sys_reset_q && trig_any) begin
            cause_q <= cause_d;
        end
    end

    // ---------------------------------------------------------------
    // reset pin drive
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rst_pin_oe     <= 1'b1;
            o_rst_pin_out    <= 1'b0;
            pin_drive_hist_q <= '0;
        end else begin
            o_rst_pin_out    <= 1'b0;
            pin_drive_hist_q <= {pin_drive_hist_q[PIN_MASK_CYCLES-2:0], o_rst_pin_oe};
            if (!sys_reset_q && trig_any) begin
                // only power-on kinds drive the pin
                o_rst_pin_oe <= cause_d[RC_POWER_ON];
            end else if (!sys_reset_q) begin
                o_rst_pin_oe <= 1'b0;
            end else if (hold_q == 8'h00 && !hold_level) begin
                o_rst_pin_oe <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // read port and status outputs
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= 8'h00;
        end else if (i_bus.rd && i_bus.addr == REG_GUARD_CONTROL) begin
            o_rd_data <= {3'h0, guard_en_q, 1'b0, interval_q};
        end else if (i_bus.rd && i_bus.addr == REG_RESET_CAUSE) begin
            // cause flags, bit 7 reads zero
            o_rd_data <= {1'b0, cause_q};
        end else begin
            o_rd_data <= 8'h00;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sys_reset    <= 1'b1;
            o_guard_active <= 1'b1;
        end else begin
            o_sys_reset    <= sys_reset_q;
            o_guard_active <= guard_en_q;
        end
    end

endmodule

`default_nettype wire

//--- dv/guard_reset_unit_asserts.sv
// concurrent checks on the ports of the guard timer and reset-cause unit
`timescale 1ns/10ps
`default_nettype none
module guard_reset_unit_asserts
#(
    parameter int CNT_W = 21
)
(
    input wire logic                 i_sys_clk,
    input wire logic                 i_reset_n,
    input wire guard_pkg::bus_req_t  i_bus,
    input wire logic [7:0]           o_rd_data,
    input wire logic                 i_rst_pin_in,
    input wire logic                 o_rst_pin_out,
    input wire logic                 o_rst_pin_oe,
    input wire logic                 i_convert_start_input,
    input wire logic                 i_comparator_out,
    input wire logic                 i_missing_clock,
    input wire logic                 i_supply_low,
    input wire logic                 i_supply_monitor_enable_pin,
    input wire logic                 o_sys_reset,
    input wire logic                 o_guard_active
);
    import guard_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    pin_out_low_a: assert property (o_rst_pin_out == 1'b0)
        else $error("reset pin output not low");
    rd_idle_zero_a: assert property (!$past(i_bus.rd) |-> o_rd_data == 8'h00)
        else $error("read data outside read slot");
    unmapped_rd_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) != REG_RESET_CAUSE
        && $past(i_bus.addr) != REG_GUARD_CONTROL |-> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    ctrl_rd_fmt_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) == REG_GUARD_CONTROL
        |-> o_rd_data[7:5] == 3'h0 && o_rd_data[3] == 1'b0)
        else $error("control read spare bits set");
    restart_on_a: assert property (i_bus.wr && i_bus.addr == REG_GUARD_CONTROL
        && i_bus.wdata == KEY_RESTART && !o_sys_reset |-> ##[1:2] o_guard_active)
        else $error("restart key did not enable");
    lock_no_on_a: assert property (i_bus.wr && i_bus.addr == REG_GUARD_CONTROL
        && i_bus.wdata == KEY_LOCK && !o_guard_active && !o_sys_reset ##1 !i_bus.wr
        |-> ##1 !o_guard_active)
        else $error("lock key enabled the timer");
    sw_reset_a: assert property (i_bus.wr && i_bus.addr == REG_RESET_CAUSE
        && i_bus.wdata == 8'h10 && !o_sys_reset |-> ##[1:3] o_sys_reset ##1 !o_rst_pin_oe [*4])
        else $error("software reset wrong");
    por_pin_a: assert property (i_bus.wr && i_bus.addr == REG_RESET_CAUSE
        && i_bus.wdata[0] && !o_sys_reset |-> ##[1:3] o_rst_pin_oe)
        else $error("forced power-on did not drive pin");
    rearm_exit_a: assert property ($fell(o_sys_reset) |-> o_guard_active)
        else $error("timer not armed after reset");
    reset_hold_a: assert property ($rose(o_sys_reset) |-> o_sys_reset [*8])
        else $error("chip reset too short");
endmodule
bind guard_reset_unit guard_reset_unit_asserts #(.CNT_W(CNT_W)) u_guard_reset_unit_asserts (.*);
`default_nettype wire

//--- dv/tb_guard_reset_unit.sv
// self-checking bench for the guard timer and reset-cause unit
`timescale 1ns/10ps
`default_nettype none
module tb_guard_reset_unit;
    import guard_pkg::*;
    logic        i_sys_clk;
    logic        i_reset_n;
    bus_req_t    bus;
    logic [7:0]  o_rd_data;
    logic        pin_n, conv_n, comp_n, miss, sup_low, oe, pin_out, sys_rst, active, r, p, mon;
    logic [7:0]  v;
    logic [7:0]  en_v [5] = '{8'h40, 8'h20, 8'h04, 8'h02, 8'h00};
    logic [7:0]  cause_v [5] = '{8'h40, 8'h20, 8'h04, 8'h02, 8'h01};
    logic        oe_v [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    int          errors, checked;
    int          seed = 32'h09F6A156;
    wire logic   pin_wire = pin_n & ~oe;

    guard_reset_unit #(.CNT_W(21)) u_guard_reset_unit (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rd_data(o_rd_data),
        .i_rst_pin_in(pin_wire), .o_rst_pin_out(pin_out), .o_rst_pin_oe(oe),
        .i_convert_start_input(conv_n), .i_comparator_out(comp_n), .i_missing_clock(miss),
        .i_supply_low(sup_low), .i_supply_monitor_enable_pin(mon),
        .o_sys_reset(sys_rst), .o_guard_active(active));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected data at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_sys_clk);
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_sys_clk);
        bus <= '0;
        @(negedge i_sys_clk);
        cmp_data(o_rd_data, exp);
        @(posedge i_sys_clk);
    endtask
    task automatic watch(input int n, output logic rs, output logic po);
        bus <= '0;
        rs = 1'b0;
        po = 1'b0;
        repeat (n) begin
            @(negedge i_sys_clk);
            rs |= sys_rst;
            po |= oe;
        end
        @(posedge i_sys_clk);
    endtask
    task automatic wait_sys(input logic lvl, input int lim);
        bus <= '0;
        repeat (lim) begin
            @(negedge i_sys_clk);
            if (sys_rst === lvl) break;
        end
        cmp_flag(sys_rst, lvl);
        @(posedge i_sys_clk);
    endtask
    task automatic src(input int s, input logic on);
        case (s)
            0: conv_n <= ~on;
            1: comp_n <= ~on;
            2: miss <= on;
            3: sup_low <= on;
            default: pin_n <= ~on;
        endcase
    endtask
    task automatic print_verdict();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #200000;
        errors++;
        print_verdict();
    end
    initial begin
        {errors, checked} = '0;
        bus = '0;
        {pin_n, conv_n, comp_n, miss, sup_low} = 5'h1C;
        mon = 1'b1;
        i_reset_n = 1'b0;
        repeat (16) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        wait_sys(1'b0, 60);
        rd_chk(REG_GUARD_CONTROL, 8'h17);
        rd_chk(REG_RESET_CAUSE, 8'h02);
        rd_chk(8'h10, 8'h00);
        bus_wr(REG_GUARD_CONTROL, KEY_RESTART);
        repeat (8) begin
            v = 8'($random(seed));
            bus_wr(REG_GUARD_CONTROL, {1'b0, v[6:0]});
            bus_wr(REG_GUARD_CONTROL, KEY_RESTART);
            v[7] = 1'b1;
            bus_wr(REG_GUARD_CONTROL, v);
            bus_wr(REG_GUARD_CONTROL, KEY_RESTART);
            rd_chk(REG_GUARD_CONTROL, {5'h02, v[2:0]});
        end
        // shortest interval: restart, then lock must not restart
        bus_wr(REG_GUARD_CONTROL, 8'h00);
        bus_wr(REG_GUARD_CONTROL, KEY_RESTART);
        watch(40, r, p);
        cmp_flag(r, 1'b0);
        bus_wr(REG_GUARD_CONTROL, KEY_LOCK);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_1);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_2);
        watch(28, r, p);
        cmp_flag(r, 1'b1);
        cmp_flag(p, 1'b0);
        wait_sys(1'b0, 80);
        rd_chk(REG_RESET_CAUSE, 8'h08);
        rd_chk(REG_GUARD_CONTROL, 8'h17);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_1);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_2);
        rd_chk(REG_GUARD_CONTROL, 8'h07);
        cmp_flag(active, 1'b0);
        bus_wr(REG_GUARD_CONTROL, KEY_RESTART);
        rd_chk(REG_GUARD_CONTROL, 8'h17);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_1);
        watch(4, r, p);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_2);
        rd_chk(REG_GUARD_CONTROL, 8'h17);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_1);
        watch(3, r, p);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_2);
        rd_chk(REG_GUARD_CONTROL, 8'h07);
        bus_wr(REG_GUARD_CONTROL, KEY_RESTART);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_1);
        bus_wr(REG_GUARD_CONTROL, 8'h05);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_2);
        rd_chk(REG_GUARD_CONTROL, 8'h15);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_1);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_2);
        // let the inactive state reach the status pin before the lock write
        watch(1, r, p);
        bus_wr(REG_GUARD_CONTROL, KEY_LOCK);
        watch(3, r, p);
        rd_chk(REG_GUARD_CONTROL, 8'h05);
        bus_wr(REG_GUARD_CONTROL, KEY_RESTART);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_1);
        bus_wr(REG_GUARD_CONTROL, KEY_DISABLE_2);
        rd_chk(REG_GUARD_CONTROL, 8'h15);
        bus_wr(REG_RESET_CAUSE, 8'h10);
        watch(6, r, p);
        cmp_flag(r, 1'b1);
        cmp_flag(p, 1'b0);
        wait_sys(1'b0, 80);
        rd_chk(REG_RESET_CAUSE, 8'h10);
        bus_wr(REG_RESET_CAUSE, 8'h01);
        watch(6, r, p);
        cmp_flag(p, 1'b1);
        wait_sys(1'b0, 80);
        rd_chk(REG_RESET_CAUSE, 8'h02);
        // sources 0 to 3: refused while not enabled, then accepted; pin source (4) accepted only
        for (int s = 0; s < 5; s++) begin
            if (s < 4) begin
                bus_wr(REG_RESET_CAUSE, 8'h00);
                src(s, 1'b1);
                watch(8, r, p);
                cmp_flag(r, 1'b0);
                src(s, 1'b0);
                watch(4, r, p);
                bus_wr(REG_RESET_CAUSE, en_v[s]);
            end
            src(s, 1'b1);
            watch(8, r, p);
            cmp_flag(r, 1'b1);
            cmp_flag(p, oe_v[s]);
            src(s, 1'b0);
            wait_sys(1'b0, 80);
            rd_chk(REG_RESET_CAUSE, cause_v[s]);
        end
        // monitor pin low: select write ignored, supply fault ignored
        mon <= 1'b0;
        watch(4, r, p);
        bus_wr(REG_RESET_CAUSE, 8'h00);
        src(3, 1'b1);
        watch(8, r, p);
        cmp_flag(r, 1'b0);
        src(3, 1'b0);
        mon <= 1'b1;
        watch(4, r, p);
        src(3, 1'b1);
        watch(8, r, p);
        cmp_flag(r, 1'b1);
        src(3, 1'b0);
        wait_sys(1'b0, 80);
        rd_chk(REG_RESET_CAUSE, 8'h02);
        print_verdict();
    end
endmodule
`default_nettype wire
